// ===== rtl/swdt_top.sv
// Software watchdog timer with Wishbone registers and fault outputs.
// Assumes a 100 MHz clock, synchronous reset and a classic Wishbone master.
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module swdt_top #(
    parameter int NTTL        = 8,
    parameter int NISO        = 4,
    parameter int TICK_CYCLES = swdt_pkg::TICK_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [7:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbWrData,
    output logic [31:0]      wbRdData,
    output logic             wbAck,
    output logic             wdogPin,
    output logic [NTTL-1:0]  ttlOut,
    output logic [NTTL-1:0]  ttlOutEn,
    output logic [NISO-1:0]  isoOut,
    output logic             irq
);
    import swdt_pkg::*;

    // ********************************************************************
    // Parameter checks
    // ********************************************************************
    generate
        if (NTTL < 1 || NTTL > 16 || NISO < 1 || NISO > 32) begin : g_bad
            $error("swdt_top: NTTL 1..16 and NISO 1..32 only");
        end
    endgenerate

    // ********************************************************************
    // Wishbone slave
    // ********************************************************************
    logic        busReq;
    logic        busWr;
    logic [31:0] byteMask;
    logic [31:0] readMux;

    assign busReq   = wbCyc && wbStb;
    assign busWr    = busReq && wbWe && wbAck;
    assign byteMask = {{8{wbSel[3]}}, {8{wbSel[2]}},
                       {8{wbSel[1]}}, {8{wbSel[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~byteMask) | (wbWrData & byteMask);
    endfunction

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= busReq && !wbAck;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wbRdData <= RST_VALUE;
        end else if (busReq && !wbAck) begin
            wbRdData <= readMux;
        end
    end

    // ********************************************************************
    // Control registers
    // ********************************************************************
    logic                   armReg;
    swdt_action_t           actionReg;
    logic                   shutEnReg;
    logic [15:0]            timeoutReg;
    logic [NTTL-1:0]        ttlOutReg;
    logic [NISO-1:0]        isoOutReg;
    logic [2*NTTL-1:0]      ttlFaultReg;
    logic [NISO-1:0]        isoFaultReg;
    logic [IRQ_W-1:0]       irqMaskReg;
    logic                   ctrlWr;
    logic                   svcWr;
    logic                   armRise;
    logic                   disarm;
    logic [31:0]            ctrlNew;
    logic [31:0]            toNew;

    assign ctrlWr  = busWr && (wbAdr == OFS_CTRL);
    assign svcWr   = busWr && (wbAdr == OFS_SERVICE);
    assign ctrlNew = merge({28'h0, shutEnReg, actionReg, armReg});
    assign toNew   = merge({16'h0, timeoutReg});
    assign armRise = ctrlWr && ctrlNew[CTRL_ARM_BIT] && !armReg;
    assign disarm  = ctrlWr && !ctrlNew[CTRL_ARM_BIT];

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            armReg    <= 1'b0;
            actionReg <= SWDT_ACT_FLAG;
            shutEnReg <= 1'b0;
        end else if (ctrlWr) begin
            armReg    <= ctrlNew[CTRL_ARM_BIT];
            actionReg <= swdt_action_t'(ctrlNew[CTRL_ACT_LSB +: 2]);
            shutEnReg <= ctrlNew[CTRL_SHUT_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            timeoutReg <= RST_TIMEOUT;
        end else if (busWr && wbAdr == OFS_TIMEOUT) begin
            timeoutReg <= (toNew[15:0] > MAX_TIMEOUT_MS) ?
                          MAX_TIMEOUT_MS : toNew[15:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ttlOutReg   <= '0;
            isoOutReg   <= '0;
            ttlFaultReg <= '0;
            isoFaultReg <= '0;
            irqMaskReg  <= '0;
        end else if (busWr) begin
            case (wbAdr)
                OFS_TTL_OUT:   ttlOutReg   <= NTTL'(merge(32'(ttlOutReg)));
                OFS_ISO_OUT:   isoOutReg   <= NISO'(merge(32'(isoOutReg)));
                OFS_TTL_FAULT: ttlFaultReg <=
                    (2*NTTL)'(merge(32'(ttlFaultReg)));
                OFS_ISO_FAULT: isoFaultReg <=
                    NISO'(merge(32'(isoFaultReg)));
                OFS_IRQ_MASK:  irqMaskReg  <=
                    IRQ_W'(merge(32'(irqMaskReg)));
                default: begin
                end
            endcase
        end
    end

    // ********************************************************************
    // Millisecond counter
    // ********************************************************************
    logic        tick;
    logic [15:0] countReg;
    logic        expiredReg;
    logic        expireEvt;
    logic        reload;

    assign reload    = armRise || (svcWr && armReg && !expiredReg);
    assign expireEvt = armReg && !expiredReg && tick && !reload &&
                       !disarm && (countReg <= 16'h1);

    swdt_tick_gen #(
        .CYCLES  (TICK_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .restart (reload),
        .tick    (tick)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            countReg <= 16'h0;
        end else if (reload) begin
            countReg <= timeoutReg;
        end else if (armReg && !expiredReg && tick && countReg != 16'h0) begin
            countReg <= countReg - 16'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            expiredReg <= 1'b0;
        end else if (expireEvt) begin
            expiredReg <= 1'b1;
        end else if (disarm) begin
            expiredReg <= 1'b0;
        end
    end

    // ********************************************************************
    // Expiry actions
    // ********************************************************************
    logic faultReg;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wdogPin <= 1'b0;
        end else if (expireEvt && actionReg == SWDT_ACT_PIN) begin
            wdogPin <= 1'b1;
        end else if (disarm) begin
            wdogPin <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            faultReg <= 1'b0;
        end else if (expireEvt && actionReg == SWDT_ACT_SHUT && shutEnReg) begin
            faultReg <= 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NTTL; gi++) begin : g_ttl
            swdt_fault_mux u_mux (
                .sys_clk   (sys_clk),
                .rst_b     (rst_b),
                .fault     (faultReg),
                .normVal   (ttlOutReg[gi]),
                .faultCode (swdt_fault_t'(ttlFaultReg[2*gi +: 2])),
                .pinOut    (ttlOut[gi]),
                .pinEn     (ttlOutEn[gi])
            );
        end
        for (gi = 0; gi < NISO; gi++) begin : g_iso
            swdt_fault_mux u_mux (
                .sys_clk   (sys_clk),
                .rst_b     (rst_b),
                .fault     (faultReg),
                .normVal   (isoOutReg[gi]),
                .faultCode (swdt_fault_t'({1'b0, isoFaultReg[gi]})),
                .pinOut    (isoOut[gi]),
                .pinEn     ()
            );
        end
    endgenerate

    // ********************************************************************
    // Interrupts
    // ********************************************************************
    logic [IRQ_W-1:0] irqStatReg;
    logic [IRQ_W-1:0] irqSet;
    logic [IRQ_W-1:0] irqClr;

    assign irqSet = {(expireEvt && actionReg == SWDT_ACT_SHUT && shutEnReg),
                     expireEvt};
    assign irqClr = (busWr && wbAdr == OFS_IRQ_STAT) ?
                    IRQ_W'(wbWrData & byteMask) : '0;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irqStatReg <= '0;
        end else begin
            irqStatReg <= (irqStatReg & ~irqClr) | irqSet;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatReg & irqMaskReg);
        end
    end

    // ********************************************************************
    // Read mux
    // ********************************************************************
    always_comb begin
        readMux = 32'h0;
        case (wbAdr)
            OFS_CTRL:      readMux = {28'h0, shutEnReg, actionReg, armReg};
            OFS_TIMEOUT:   readMux = {16'h0, timeoutReg};
            OFS_STATUS: begin
                readMux[ST_EXPIRED_BIT] = expiredReg;
                readMux[ST_PIN_BIT]     = wdogPin;
                readMux[ST_FAULT_BIT]   = faultReg;
                readMux[ST_ARMED_BIT]   = armReg;
            end
            OFS_COUNT:     readMux = {16'h0, countReg};
            OFS_IRQ_STAT:  readMux = 32'(irqStatReg);
            OFS_IRQ_MASK:  readMux = 32'(irqMaskReg);
            OFS_TTL_OUT:   readMux = 32'(ttlOutReg);
            OFS_ISO_OUT:   readMux = 32'(isoOutReg);
            OFS_TTL_FAULT: readMux = 32'(ttlFaultReg);
            OFS_ISO_FAULT: readMux = 32'(isoFaultReg);
            default:       readMux = 32'h0;
        endcase
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    property p_count_step;
        (armReg && !expiredReg && tick && !reload && countReg > 16'h1)
        |=> countReg == $past(countReg) - 16'h1;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step by one per tick");

    property p_timeout_max;
        timeoutReg <= MAX_TIMEOUT_MS;
    endproperty
    a_timeout_max: assert property (p_timeout_max)
        else $error("timeout above the limit");

    property p_action_pin;
        (expireEvt && actionReg == SWDT_ACT_PIN) |=> wdogPin && expiredReg;
    endproperty
    a_action_pin: assert property (p_action_pin)
        else $error("pin action not taken on expiry");

    property p_flag_set;
        expireEvt |=> expiredReg ##0 irqStatReg[IRQ_EXPIRE_BIT];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("expired indicator not set");

    property p_flag_hold;
        (expiredReg && !disarm) |=> expiredReg;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("expired indicator dropped without disarm");

    property p_flag_clear;
        (disarm && !expireEvt) |=> !expiredReg && !wdogPin;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("disarm did not clear indicator");

    property p_pin_low;
        !expiredReg |-> !wdogPin;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("watchdog pin high without expiry");

    property p_pin_hold;
        (wdogPin && !disarm) |=> wdogPin;
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("watchdog pin dropped without disarm");

    property p_fault_cause;
        $rose(faultReg) |-> $past(expireEvt) && $past(shutEnReg) &&
                            $past(actionReg) == SWDT_ACT_SHUT;
    endproperty
    a_fault_cause: assert property (p_fault_cause)
        else $error("fault raised without enabled shutdown expiry");

    property p_fault_apply;
        (expireEvt && actionReg == SWDT_ACT_SHUT && shutEnReg)
        |=> faultReg ##1 (isoOut == $past(isoFaultReg)) ##0 faultReg;
    endproperty
    a_fault_apply: assert property (p_fault_apply)
        else $error("shutdown expiry did not force fault");

    property p_fault_sticky;
        faultReg |=> faultReg [*4];
    endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("fault state left before reset");

endmodule // swdt_top
`default_nettype wire

// ===== rtl/swdt_pkg.sv
// Package of the software watchdog timer: register map, fields, timing.
// Assumes a 100 MHz system clock and a 32-bit Wishbone register bus.
package swdt_pkg;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_PERIOD_NS = 1_000_000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [15:0] MAX_TIMEOUT_MS = 16'd65534;

    // ********************************************************************
    // Register byte offsets
    // ********************************************************************
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_TIMEOUT   = 8'h04;
    localparam logic [7:0] OFS_SERVICE   = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0c;
    localparam logic [7:0] OFS_COUNT     = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;
    localparam logic [7:0] OFS_TTL_OUT   = 8'h1c;
    localparam logic [7:0] OFS_ISO_OUT   = 8'h20;
    localparam logic [7:0] OFS_TTL_FAULT = 8'h24;
    localparam logic [7:0] OFS_ISO_FAULT = 8'h28;

    // ********************************************************************
    // Fields
    // ********************************************************************
    localparam int CTRL_ARM_BIT   = 0;
    localparam int CTRL_ACT_LSB   = 1;
    localparam int CTRL_SHUT_BIT  = 3;
    localparam int ST_EXPIRED_BIT = 0;
    localparam int ST_PIN_BIT     = 1;
    localparam int ST_FAULT_BIT   = 2;
    localparam int ST_ARMED_BIT   = 3;
    localparam int IRQ_EXPIRE_BIT = 0;
    localparam int IRQ_FAULT_BIT  = 1;
    localparam int IRQ_W          = 2;

    localparam logic [31:0] RST_VALUE    = 32'h0000_0000;
    localparam logic [15:0] RST_TIMEOUT  = 16'hffff & 16'd1000;

    typedef enum logic [1:0] {
        SWDT_ACT_FLAG  = 2'b00,
        SWDT_ACT_PIN   = 2'b01,
        SWDT_ACT_SHUT  = 2'b10,
        SWDT_ACT_RSVD  = 2'b11
    } swdt_action_t;

    typedef enum logic [1:0] {
        SWDT_FLT_LOW  = 2'b00,
        SWDT_FLT_HIGH = 2'b01,
        SWDT_FLT_HIZ  = 2'b10,
        SWDT_FLT_KEEP = 2'b11
    } swdt_fault_t;

endpackage

// ===== rtl/swdt_tick_gen.sv
// Millisecond tick divider of the software watchdog timer.
// Assumes one system clock; restart realigns the tick phase.
`timescale 1ns/10ps
`default_nettype none
module swdt_tick_gen #(
    parameter int CYCLES = 100000
) (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic restart,
    output logic      tick
);
    import swdt_pkg::*;

    // ********************************************************************
    // Divider
    // ********************************************************************
    generate
        if (CYCLES < 2) begin : g_bad
            $error("swdt_tick_gen: CYCLES must be at least 2");
        end
    endgenerate

    logic [31:0] divReg;

    always_ff @(posedge sys_clk) begin
        if (!rst_b || restart) begin
            divReg <= 32'h0;
        end else if (divReg == 32'(CYCLES - 1)) begin
            divReg <= 32'h0;
        end else begin
            divReg <= divReg + 32'h1;
        end
    end

    assign tick = rst_b && !restart && (divReg == 32'(CYCLES - 1));

endmodule // swdt_tick_gen
`default_nettype wire

// ===== rtl/swdt_fault_mux.sv
// One output line of the watchdog: normal value or latched fault state.
// Assumes fault stays high once raised; pin levels resolved outside.
`timescale 1ns/10ps
`default_nettype none
module swdt_fault_mux (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 fault,
    input  wire logic                 normVal,
    input  wire swdt_pkg::swdt_fault_t faultCode,
    output logic                      pinOut,
    output logic                      pinEn
);
    import swdt_pkg::*;

    // ********************************************************************
    // Output select
    // ********************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pinOut <= 1'b0;
            pinEn  <= 1'b1;
        end else if (fault) begin
            case (faultCode)
                SWDT_FLT_LOW: begin
                    pinOut <= 1'b0;
                    pinEn  <= 1'b1;
                end
                SWDT_FLT_HIGH: begin
                    pinOut <= 1'b1;
                    pinEn  <= 1'b1;
                end
                SWDT_FLT_HIZ: begin
                    pinOut <= 1'b0;
                    pinEn  <= 1'b0;
                end
                default: begin
                    pinOut <= pinOut;
                    pinEn  <= pinEn;
                end
            endcase
        end else begin
            pinOut <= normVal;
            pinEn  <= 1'b1;
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    property p_fault_hiz;
        @(posedge sys_clk) disable iff (!rst_b)
        (fault && faultCode == SWDT_FLT_HIZ) |=> !pinEn;
    endproperty
    a_fault_hiz: assert property (p_fault_hiz)
        else $error("fault state high impedance not applied");

endmodule // swdt_fault_mux
`default_nettype wire

// ===== tb/swdt_testbench.sv
// Self-checking bench of the software watchdog timer.
// Assumes swdt_top with a ten-cycle tick and a classic Wishbone master.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import swdt_pkg::*;

    // ****************************************************************
    // Signals and rows
    // ****************************************************************
    localparam int          TCK   = 10;
    localparam int          LIMIT = 20000;
    localparam logic [7:0]  NORM  = 8'h5a;

    typedef struct packed {
        logic [1:0]  act;
        logic        shut;
        logic [15:0] ms;
        logic        pin;
        logic        flt;
    } swdt_row_t;

    swdt_row_t rows [5] = '{
        '{2'h0, 1'b0, 16'h0003, 1'b0, 1'b0},
        '{2'h1, 1'b0, 16'h0001, 1'b1, 1'b0},
        '{2'h2, 1'b1, 16'h0002, 1'b0, 1'b1},
        '{2'h2, 1'b0, 16'h0002, 1'b0, 1'b0},
        '{2'h3, 1'b1, 16'h0000, 1'b0, 1'b0}
    };

    logic        sys_clk  = 1'b0;
    logic        rst_b    = 1'b0;
    logic        wbCyc    = 1'b0;
    logic        wbStb    = 1'b0;
    logic        wbWe     = 1'b0;
    logic [7:0]  wbAdr    = 8'h00;
    logic [3:0]  wbSel    = 4'h0;
    logic [31:0] wbWrData = 32'h0;
    logic [31:0] wbRdData;
    logic        wbAck;
    logic        wdogPin;
    logic [7:0]  ttlOut;
    logic [7:0]  ttlOutEn;
    logic [3:0]  isoOut;
    logic        irq;
    logic [31:0] q;
    logic [3:0]  ctl;
    int          n_errors   = 0;
    int          n_compared = 0;
    int          cycles     = 0;

    always #5 sys_clk = ~sys_clk;

    swdt_top #(.NTTL(8), .NISO(4), .TICK_CYCLES(TCK)) i_dut (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .wbCyc    (wbCyc),
        .wbStb    (wbStb),
        .wbWe     (wbWe),
        .wbAdr    (wbAdr),
        .wbSel    (wbSel),
        .wbWrData (wbWrData),
        .wbRdData (wbRdData),
        .wbAck    (wbAck),
        .wdogPin  (wdogPin),
        .ttlOut   (ttlOut),
        .ttlOutEn (ttlOutEn),
        .isoOut   (isoOut),
        .irq      (irq)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors = n_errors + 1;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s saw %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        rst_b <= 1'b0;
        wait_cyc(10);
        rst_b <= 1'b1;
    endtask

    task automatic wb_cycle(input logic we, input logic [7:0] a,
                            input logic [3:0] s, input logic [31:0] d);
        @(posedge sys_clk);
        wbCyc    <= 1'b1;
        wbStb    <= 1'b1;
        wbWe     <= we;
        wbAdr    <= a;
        wbSel    <= s;
        wbWrData <= d;
        do @(posedge sys_clk); while (wbAck !== 1'b1);
        q = wbRdData;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_cycle(1'b1, a, 4'hf, d);
    endtask

    task automatic rd(input logic [7:0] a);
        wb_cycle(1'b0, a, 4'hf, 32'h0);
    endtask

    task automatic chk_out(input logic f);
        logic [7:0] eo;
        logic [7:0] ee;
        int         c;
        for (int i = 0; i < 8; i++) begin
            c = i % 4;
            ee[i] = !(f && c == 2);
            eo[i] = f ? (c == 1 || (c == 3 && NORM[i])) : NORM[i];
        end
        check({24'h0, ttlOutEn}, {24'h0, ee}, "enables");
        check({24'h0, ttlOut & ee}, {24'h0, eo & ee}, "ttl");
        check({28'h0, isoOut}, f ? 32'ha : 32'h3, "iso");
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        wait_cyc(10);
        rst_b <= 1'b1;
        foreach (rows[r]) begin
            do_reset();
            wr(OFS_TTL_OUT, {24'h0, NORM});
            wr(OFS_ISO_OUT, 32'h3);
            wr(OFS_TTL_FAULT, 32'he4e4);
            wr(OFS_ISO_FAULT, 32'ha);
            wr(OFS_IRQ_MASK, 32'h3);
            wr(OFS_TIMEOUT, {16'h0, rows[r].ms});
            ctl = {rows[r].shut, rows[r].act, 1'b1};
            wr(OFS_CTRL, {28'h0, ctl});
            chk_out(1'b0);
            if (rows[r].ms != 0) begin
                wait_cyc(rows[r].ms * TCK - 6);
                check({31'h0, wdogPin}, 32'h0, "pin early");
                rd(OFS_STATUS);
                check(q & 32'h1, 32'h0, "flag early");
            end
            wait_cyc(12);
            rd(OFS_STATUS);
            check(q, {28'h0, 1'b1, rows[r].flt, rows[r].pin, 1'b1},
                  "st");
            check({31'h0, wdogPin}, {31'h0, rows[r].pin}, "pin");
            chk_out(rows[r].flt);
            check({31'h0, irq}, 32'h1, "irq set");
            wr(OFS_CTRL, {28'h0, ctl & 4'he});
            rd(OFS_STATUS);
            check(q, {29'h0, rows[r].flt, 2'b00}, "disarmed");
            check({31'h0, wdogPin}, 32'h0, "pin off");
            chk_out(rows[r].flt);
            wr(OFS_IRQ_STAT, 32'h3);
            wait_cyc(2);
            check({31'h0, irq}, 32'h0, "irq clear");
            $display("row %0d done", r);
        end
        do_reset();
        check({24'h0, ttlOut}, 32'h0, "ttl after reset");
        check({24'h0, ttlOutEn}, 32'hff, "enables after reset");
        check({28'h0, isoOut}, 32'h0, "iso after reset");
        check({30'h0, wdogPin, irq}, 32'h0, "pin irq after reset");
        wr(OFS_TTL_OUT, {24'h0, NORM});
        wr(OFS_ISO_OUT, 32'h3);
        wait_cyc(2);
        chk_out(1'b0);
        rd(OFS_TIMEOUT);
        check(q, 32'h3e8, "timeout reset");
        rd(8'h3c);
        check(q, 32'h0, "unmapped");
        wr(OFS_TIMEOUT, 32'hffff);
        rd(OFS_TIMEOUT);
        check(q, {16'h0, MAX_TIMEOUT_MS}, "clamp");
        wb_cycle(1'b1, OFS_TIMEOUT, 4'h1, 32'h77);
        rd(OFS_TIMEOUT);
        check(q, 32'hff77, "byte lane");
        $display("registers done");
        wr(OFS_TIMEOUT, 32'h3);
        wr(OFS_CTRL, 32'h1);
        repeat (6) begin
            wait_cyc(20);
            wr(OFS_SERVICE, 32'h0);
        end
        rd(OFS_COUNT);
        check(q, 32'h3, "reloaded");
        rd(OFS_STATUS);
        check(q, 32'h8, "serviced");
        wait_cyc(40);
        rd(OFS_STATUS);
        check(q, 32'h9, "expired");
        check({31'h0, irq}, 32'h0, "masked");
        wr(OFS_SERVICE, 32'h0);
        rd(OFS_STATUS);
        check(q, 32'h9, "late service");
        rd(OFS_COUNT);
        check(q, 32'h0, "count halted");
        wr(OFS_IRQ_MASK, 32'h1);
        wait_cyc(2);
        check({31'h0, irq}, 32'h1, "unmasked");
        wr(OFS_IRQ_STAT, 32'h1);
        wait_cyc(2);
        check({31'h0, irq}, 32'h0, "w1c");
        $display("service done");
        test_done();
    end

endmodule // testbench
`default_nettype wire
